/* File: design/cfg_bank_pkg.sv */
// constants, types and register layout for the configuration register bank
package cfg_bank_pkg;

  // host port addresses
  localparam logic [9:0] INDEX_PORT_ADDR = 10'h3F0;
  localparam logic [9:0] DATA_PORT_ADDR  = 10'h3F1;
  localparam int         ADDR_W          = 10;
  localparam int         DATA_W          = 8;

  // key values written to the index port
  localparam logic [7:0] UNLOCK_KEY_BASE  = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_ALT   = 8'h44;
  localparam logic [7:0] EXIT_KEY         = 8'hAA;

  // configuration register space
  localparam int         CFG_REG_COUNT   = 16;
  localparam int         CFG_IDX_W       = 4;
  localparam logic [7:0] CFG_IDX_LIMIT   = 8'h0F;

  // register indices
  localparam logic [3:0] IDX_CTRL        = 4'h0;
  localparam logic [3:0] IDX_PORT        = 4'h1;
  localparam logic [3:0] IDX_SERIAL      = 4'h2;
  localparam logic [3:0] IDX_DRIVE       = 4'h3;
  localparam logic [3:0] IDX_DRIVE_TYPES = 4'h6;
  localparam logic [3:0] IDX_IDENT       = 4'hD;
  localparam logic [3:0] IDX_FIXED       = 4'hE;

  // power-up defaults
  localparam logic [7:0] CTRL_RESET_BASE = 8'h3B;
  localparam logic [7:0] CTRL_RESET_ALT  = 8'h2B;
  localparam logic [7:0] PORT_RESET      = 8'h9F;
  localparam logic [7:0] SERIAL_RESET    = 8'hDC;
  localparam logic [7:0] DRIVE_RESET     = 8'h78;
  localparam logic [7:0] DRIVE_TYP_RESET = 8'hFF;
  localparam logic [7:0] FIXED_VALUE     = 8'h01;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;

  // writable bit masks
  localparam logic [7:0] CTRL_WMASK      = 8'hFB;
  localparam logic [7:0] DRIVE_WMASK     = 8'hFE;
  localparam logic [7:0] FULL_WMASK      = 8'hFF;

  // control register zero field positions
  localparam int         CTRL_DISK_EN_BIT    = 0;
  localparam int         CTRL_DISK_STYLE_BIT = 1;
  localparam int         CTRL_FLOPPY_PWR_BIT = 3;
  localparam int         CTRL_FLOPPY_EN_BIT  = 4;
  localparam int         CTRL_OSC_LSB        = 5;
  localparam int         CTRL_OSC_MSB        = 6;

  // oscillator field encodings
  localparam logic [1:0] OSC_ALWAYS_ON   = 2'h0;
  localparam logic [1:0] OSC_ALL_OFF     = 2'h3;

  typedef enum {
    ST_LOCKED,
    ST_KEY_SEEN,
    ST_CONFIG
  } cfg_mode_t;

  typedef struct packed {
    logic              wr_n;
    logic              rd_n;
    logic              power_good_input;
    logic              sys_reset;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } host_pins_t;

  localparam int         HOST_PINS_W     = 4 + ADDR_W + DATA_W;
  localparam logic [HOST_PINS_W-1:0] HOST_PINS_IDLE = {2'h3, 2'h0, 18'h00000};

  typedef struct packed {
    logic osc_enable;
    logic baud_clock_generator;
    logic floppy_enable;
    logic floppy_power_control;
    logic disk_interface_style;
    logic disk_interface_enable;
  } ctrl_out_t;

endpackage : cfg_bank_pkg

/* File: design/pin_sync.sv */
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage is read by the second stage only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pin_sync
`default_nettype wire

/* File: design/config_register_bank.sv */
// index/data configuration register bank with key-unlocked configuration mode
// Function
// R1 - two consecutive unlock key writes to index port enter configuration mode
// R2 - any other write between the two key writes restarts key detection
// R3 - exit key written to index port leaves configuration mode
// R4 - index port writes in configuration mode load the select register
// R5 - select register ignores writes outside configuration mode
// R6 - select register must be written first; it steers data port accesses
// R7 - data port reads and writes reach the selected configuration register
// R8 - one select register plus sixteen configuration registers zero to fifteen
// R9 - power-up loads defaults; system reset leaves configuration registers untouched
// R10 - control register zero reached only at index zero; default depends on variant
// R11 - control bit 0 enables disk interface decode, default on
// R12 - control bit 1 picks at-style disk decode when set, default at
// R13 - control bit 2 reserved, written zero, has no function
// R14 - control bit 3 keeps floppy controller powered when set, default on
// R15 - control bit 4 enables floppy controller when set
// R16 - oscillator field: 00 on, 01/10 follow power good, 11 off
// R17 - control bit 7 software valid flag, cleared at power-up
// R18 - outside configuration mode ports are left to normal decoders, no changes
// R19 - power-on reset clears mode and select and loads all defaults
`timescale 1ns/1ps
`default_nettype none
module config_register_bank
  import cfg_bank_pkg::*;
#(
  parameter int         VARIANT    = 0,
  parameter logic [7:0] IDENT_CODE = 8'h5A  // arbitrary identification value
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              io_wr_n,
  input  wire logic              io_rd_n,
  input  wire logic [ADDR_W-1:0] io_addr,
  input  wire logic [DATA_W-1:0] io_data_in,
  input  wire logic              sys_reset,
  input  wire logic              power_good_input,
  output var  logic [DATA_W-1:0] io_data_out,
  output var  logic              io_data_oe,
  output logic                   port_claim,
  output logic                   config_active,
  output var  ctrl_out_t         ctrl
);

  if (VARIANT < 0 || VARIANT > 1) begin : g_bad_variant
    $error("VARIANT must be 0 or 1");
  end

  localparam logic [7:0] UNLOCK_KEY = (VARIANT == 1) ? UNLOCK_KEY_ALT : UNLOCK_KEY_BASE;
  // R10 R17 variant picks the default; the valid flag starts clear in both
  localparam logic [7:0] CTRL_RESET = (VARIANT == 1) ? CTRL_RESET_ALT : CTRL_RESET_BASE;

  // power-up default of each configuration register
  function automatic logic [7:0] default_of(input logic [3:0] idx);
    logic [7:0] v;
    v = ZERO_BYTE;
    if (idx == IDX_CTRL) begin
      v = CTRL_RESET;
    end else if (idx == IDX_PORT) begin
      v = PORT_RESET;
    end else if (idx == IDX_SERIAL) begin
      v = SERIAL_RESET;
    end else if (idx == IDX_DRIVE) begin
      v = DRIVE_RESET;
    end else if (idx == IDX_DRIVE_TYPES) begin
      v = DRIVE_TYP_RESET;
    end else if (idx == IDX_IDENT) begin
      v = IDENT_CODE;
    end else if (idx == IDX_FIXED) begin
      v = FIXED_VALUE;
    end
    return v;
  endfunction : default_of

  // bits that software may change; read-only and reserved registers take none
  function automatic logic [7:0] wmask_of(input logic [3:0] idx);
    logic [7:0] m;
    m = FULL_WMASK;
    if (idx == IDX_CTRL) begin
      m = CTRL_WMASK;
    end else if (idx == IDX_DRIVE) begin
      m = DRIVE_WMASK;
    end else if (idx >= 4'hA) begin
      m = ZERO_BYTE;
    end
    return m;
  endfunction : wmask_of

  // ---- pin capture ----
  host_pins_t pins_raw;
  host_pins_t pins;
  logic       wr_n_d_r;
  logic       rd_n_d_r;

  assign pins_raw = '{wr_n: io_wr_n, rd_n: io_rd_n, power_good_input: power_good_input,
                      sys_reset: sys_reset, addr: io_addr, data: io_data_in};

  // address and data are quasi-static around the strobes, so one sampling of the group is safe
  pin_sync #(
    .W       (HOST_PINS_W),
    .RST_VAL (HOST_PINS_IDLE)
  ) u_pin_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (pins_raw),
    .q      (pins)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_n_d_r <= 1'b1;
      rd_n_d_r <= 1'b1;
    end else begin
      wr_n_d_r <= pins.wr_n;
      rd_n_d_r <= pins.rd_n;
    end
  end

  // a write is taken at the trailing edge of the strobe, when data is settled
  logic wr_evt;
  logic rd_active;
  logic wr_index;
  logic wr_data;
  assign wr_evt    = pins.wr_n && !wr_n_d_r;
  assign rd_active = !pins.rd_n && !rd_n_d_r;
  assign wr_index  = wr_evt && (pins.addr == INDEX_PORT_ADDR);
  assign wr_data   = wr_evt && (pins.addr == DATA_PORT_ADDR);

  // ---- mode state machine ----
  cfg_mode_t mode_r;
  cfg_mode_t mode_nxt;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      ST_LOCKED: begin
        // R1 first key write
        if (wr_index && pins.data == UNLOCK_KEY) begin
          mode_nxt = ST_KEY_SEEN;
        end
      end
      ST_KEY_SEEN: begin
        // R1 second key completes unlock
        if (wr_index && pins.data == UNLOCK_KEY) begin
          mode_nxt = ST_CONFIG;
        // R2 any other write restarts detection
        end else if (wr_evt || pins.sys_reset) begin
          mode_nxt = ST_LOCKED;
        end
      end
      ST_CONFIG: begin
        // R3 exit key
        if (wr_index && pins.data == EXIT_KEY) begin
          mode_nxt = ST_LOCKED;
        end
      end
      default: mode_nxt = ST_LOCKED;
    endcase
  end

  // R19 power-on reset returns to locked mode
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= ST_LOCKED;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign config_active = (mode_r == ST_CONFIG);

  // ---- select register ----
  logic [7:0] sel_r;
  logic       sel_valid_r;
  logic       sel_in_range;
  logic [3:0] sel_idx;
  logic       access_ok;
  assign sel_in_range = (sel_r <= CFG_IDX_LIMIT);
  assign sel_idx      = sel_r[CFG_IDX_W-1:0];
  // R6 data port reaches a register only after the select register was written
  assign access_ok    = config_active && sel_valid_r && sel_in_range;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_r       <= ZERO_BYTE;
      sel_valid_r <= 1'b0;
    end else begin
      if (mode_r != ST_CONFIG && mode_nxt == ST_CONFIG) begin
        sel_valid_r <= 1'b0;
      // R4 R5 load only while configuration mode is active
      end else if (config_active && wr_index && pins.data != EXIT_KEY) begin
        sel_r       <= pins.data;
        sel_valid_r <= 1'b1;
      end
    end
  end

  // ---- configuration registers ----
  // R8 sixteen registers addressed by the select index
  logic [7:0] cfg_r [CFG_REG_COUNT];

  // R9 only power-on reset loads defaults; system reset is not wired here
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < CFG_REG_COUNT; i++) begin
        cfg_r[i] <= default_of(4'(i));
      end
    // R7 R18 writes land only in configuration mode
    end else if (wr_data && access_ok) begin
      // R13 masked bits keep their value and read as stored
      cfg_r[sel_idx] <= (cfg_r[sel_idx] & ~wmask_of(sel_idx)) | (pins.data & wmask_of(sel_idx));
    end
  end

  // ---- host read path ----
  // R7 selected register driven onto the data bus during a read
  // R18 port_claim low leaves the ports to the normal function decoders
  assign port_claim = config_active &&
                      (pins.addr == INDEX_PORT_ADDR || pins.addr == DATA_PORT_ADDR);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      io_data_out <= ZERO_BYTE;
      io_data_oe  <= 1'b0;
    end else begin
      io_data_oe  <= rd_active && access_ok && (pins.addr == DATA_PORT_ADDR);
      io_data_out <= cfg_r[sel_idx];
    end
  end

  // ---- control register zero decode ----
  logic [7:0] ctrl_reg;
  logic [1:0] osc_mode;
  logic       osc_on;
  assign ctrl_reg = cfg_r[IDX_CTRL];
  assign osc_mode = ctrl_reg[CTRL_OSC_MSB:CTRL_OSC_LSB];

  // R16 middle codes follow the synchronised power good level
  always_comb begin
    if (osc_mode == OSC_ALWAYS_ON) begin
      osc_on = 1'b1;
    end else if (osc_mode == OSC_ALL_OFF) begin
      osc_on = 1'b0;
    end else begin
      osc_on = pins.power_good_input;
    end
  end

  // registered so the control outputs never glitch on a data port write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= '0;
    end else begin
      // R11 disk interface enable
      ctrl.disk_interface_enable <= ctrl_reg[CTRL_DISK_EN_BIT];
      // R12 at or xt style
      ctrl.disk_interface_style  <= ctrl_reg[CTRL_DISK_STYLE_BIT];
      // R14 floppy power
      ctrl.floppy_power_control  <= ctrl_reg[CTRL_FLOPPY_PWR_BIT];
      // R15 floppy enable
      ctrl.floppy_enable         <= ctrl_reg[CTRL_FLOPPY_EN_BIT];
      // R16 oscillator and baud clock share one gate
      ctrl.osc_enable            <= osc_on;
      ctrl.baud_clock_generator  <= osc_on;
    end
  end

  // ---- assertions ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_key_unlock: assert property ( // R1
    (mode_r == ST_KEY_SEEN && wr_index && pins.data == UNLOCK_KEY) |=> config_active)
    else $error("second unlock key did not enter configuration mode");

  chk_key_single: assert property ( // R1
    (mode_r == ST_LOCKED) |=> (mode_r != ST_CONFIG))
    else $error("configuration mode entered on a single key write");

  chk_key_abort: assert property ( // R2
    (mode_r == ST_KEY_SEEN && wr_evt && pins.addr != INDEX_PORT_ADDR) |=> (mode_r == ST_LOCKED))
    else $error("foreign write did not restart key detection");

  chk_exit_key: assert property ( // R3
    (config_active && wr_index && pins.data == EXIT_KEY) |=> (mode_r == ST_LOCKED) ##1 !io_data_oe)
    else $error("exit key did not leave configuration mode");

  chk_sel_load: assert property ( // R4
    (config_active && wr_index && pins.data != EXIT_KEY) |=> (sel_r == $past(pins.data) && sel_valid_r))
    else $error("select register not loaded from index write");

  chk_sel_hold: assert property ( // R5
    !config_active |=> $stable(sel_r))
    else $error("select register changed outside configuration mode");

  chk_data_write: assert property ( // R7
    (wr_data && access_ok && sel_idx == IDX_DRIVE_TYPES) |=> (cfg_r[IDX_DRIVE_TYPES] == $past(pins.data)))
    else $error("data port write did not reach selected register");

  chk_ctrl_guard: assert property ( // R10
    (cfg_r[IDX_CTRL] != $past(cfg_r[IDX_CTRL])) |-> $past(wr_data && access_ok && sel_idx == IDX_CTRL))
    else $error("control register zero changed without an index zero write");

  chk_no_touch: assert property ( // R18
    (!config_active && !$past(config_active)) |-> (!io_data_oe && !port_claim && $stable(cfg_r[IDX_CTRL])))
    else $error("configuration ports active outside configuration mode");

  chk_reserved: assert property ( // R13
    cfg_r[IDX_CTRL][2] == 1'b0)
    else $error("reserved control bit became set");

  chk_osc_off: assert property ( // R16
    (osc_mode == OSC_ALL_OFF) ##1 (osc_mode == OSC_ALL_OFF) |-> !ctrl.osc_enable && !ctrl.baud_clock_generator)
    else $error("oscillator not off for code three");

  chk_sel_fresh: assert property ( // R6
    (mode_r != ST_CONFIG && mode_nxt == ST_CONFIG) |=> !sel_valid_r)
    else $error("select register still valid after entering configuration mode");

  chk_read_drive: assert property ( // R7
    (rd_active && access_ok && pins.addr == DATA_PORT_ADDR) |=> (io_data_oe && io_data_out == $past(cfg_r[sel_idx])))
    else $error("data port read did not drive the selected register");

  chk_fixed_reg: assert property ( // R8
    cfg_r[IDX_FIXED] == FIXED_VALUE)
    else $error("fixed register lost its value");

  chk_osc_follow: assert property ( // R16
    (osc_mode != OSC_ALWAYS_ON && osc_mode != OSC_ALL_OFF) |=> (ctrl.osc_enable == $past(pins.power_good_input)))
    else $error("oscillator does not follow power good");

  chk_key_sysreset: assert property ( // R2
    (mode_r == ST_KEY_SEEN && pins.sys_reset && !wr_evt) |=> (mode_r == ST_LOCKED))
    else $error("system reset did not drop a half-entered key");

  cov_unlock: cover property (mode_r == ST_KEY_SEEN ##1 config_active);
  cov_exit: cover property (config_active ##1 !config_active);
  cov_abort: cover property (mode_r == ST_KEY_SEEN ##1 mode_r == ST_LOCKED);
  cov_ctrl_write: cover property (wr_data && access_ok && sel_idx == IDX_CTRL);
  cov_read: cover property (io_data_oe);

endmodule : config_register_bank
`default_nettype wire

/* File: design/README_unused_placeholder_removed.sv */
// intentionally empty compilation unit for tool file lists
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verification/host_bus_model.sv */
// host processor model that drives the index and data port pins
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import cfg_bank_pkg::*;
(
  input  wire logic              mclk,
  output var  logic              io_wr_n,
  output var  logic              io_rd_n,
  output var  logic [ADDR_W-1:0] io_addr,
  output var  logic [DATA_W-1:0] io_data_in,
  input  wire logic [DATA_W-1:0] io_data_out,
  input  wire logic              io_data_oe
);
  initial begin
    io_wr_n    = 1'b1;
    io_rd_n    = 1'b1;
    io_addr    = INDEX_PORT_ADDR;
    io_data_in = 8'hA5;
  end

  // strobe timing
  // write strobe stays low five cycles, read strobe seven, both high six or more; the pin synchroniser needs two
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    #1;
    io_addr    = a;
    io_data_in = d;
    io_wr_n    = 1'b0;
    repeat (5) @(posedge mclk);
    #1 io_wr_n = 1'b1;
    repeat (4) @(posedge mclk);
    // released bus floats; show the inverse so stale data is never taken
    #1 io_data_in = ~d;
    repeat (4) @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic oe);
    @(posedge mclk);
    #1;
    io_addr = a;
    io_rd_n = 1'b0;
    repeat (7) @(posedge mclk);
    #1;
    d       = io_data_out;
    oe      = io_data_oe;
    io_rd_n = 1'b1;
    repeat (6) @(posedge mclk);
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

/* File: verification/config_register_bank_tb_top.sv */
// self-checking testbench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module config_register_bank_tb_top;
  import cfg_bank_pkg::*;
  localparam logic [7:0] IDENT = 8'h5A;  // arbitrary identification value

  logic              mclk;
  logic              arst_n;
  logic              sys_reset;
  logic              power_good_input;
  logic              io_wr_n;
  logic              io_rd_n;
  logic [ADDR_W-1:0] io_addr;
  logic [DATA_W-1:0] io_data_in;
  logic [DATA_W-1:0] io_data_out;
  logic              io_data_oe;
  logic              port_claim;
  logic              config_active;
  ctrl_out_t         ctrl;
  ctrl_out_t         alt_ctrl;
  logic              alt_active;
  logic [DATA_W-1:0] rdata;
  logic              roe;
  int                bad_count;
  int                cmp_count;
  logic [7:0]        dflt [16] = '{8'h3B, 8'h9F, 8'hDC, 8'h78, 8'h00, 8'h00, 8'hFF, 8'h00,
                                   8'h00, 8'h00, 8'h00, 8'h00, 8'h00, IDENT, 8'h01, 8'h00};

  config_register_bank #(.VARIANT(0), .IDENT_CODE(IDENT)) uut (
    .mclk(mclk), .arst_n(arst_n), .io_wr_n(io_wr_n), .io_rd_n(io_rd_n), .io_addr(io_addr),
    .io_data_in(io_data_in), .sys_reset(sys_reset), .power_good_input(power_good_input),
    .io_data_out(io_data_out), .io_data_oe(io_data_oe), .port_claim(port_claim),
    .config_active(config_active), .ctrl(ctrl));

  config_register_bank #(.VARIANT(1), .IDENT_CODE(IDENT)) uut_alt (
    .mclk(mclk), .arst_n(arst_n), .io_wr_n(io_wr_n), .io_rd_n(io_rd_n), .io_addr(io_addr),
    .io_data_in(io_data_in), .sys_reset(sys_reset), .power_good_input(power_good_input),
    .io_data_out(), .io_data_oe(), .port_claim(), .config_active(alt_active), .ctrl(alt_ctrl));

  host_bus_model host (
    .mclk(mclk), .io_wr_n(io_wr_n), .io_rd_n(io_rd_n), .io_addr(io_addr),
    .io_data_in(io_data_in), .io_data_out(io_data_out), .io_data_oe(io_data_oe));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic enter();
    host.wr(INDEX_PORT_ADDR, UNLOCK_KEY_BASE);
    host.wr(INDEX_PORT_ADDR, UNLOCK_KEY_BASE);
  endtask : enter

  task automatic wrreg(input logic [3:0] idx, input logic [7:0] v);
    host.wr(INDEX_PORT_ADDR, {4'h0, idx});
    host.wr(DATA_PORT_ADDR, v);
  endtask : wrreg

  task automatic rdreg(input logic [3:0] idx, input logic [7:0] exp);
    host.wr(INDEX_PORT_ADDR, {4'h0, idx});
    host.rd(DATA_PORT_ADDR, rdata, roe);
    chk({7'h0, roe}, 8'h01);
    chk(rdata, exp);
  endtask : rdreg

  // oscillator and baud clock follow the code and, for 01 and 10, power good
  function automatic logic [7:0] ctrl_exp(input logic [7:0] v, input logic pg);
    logic osc_on;
    osc_on = (v[6:5] == 2'h0) || (v[6:5] != 2'h3 && pg);
    return {2'h0, osc_on, osc_on, v[4], v[3], v[1], v[0]};
  endfunction : ctrl_exp

  initial begin
    #50000;
    bad_count++;
    finish_test();
  end

  initial begin
    logic [7:0] v;
    bad_count        = 0;
    cmp_count        = 0;
    sys_reset        = 1'b0;
    power_good_input = 1'b0;
    arst_n           = 1'b0;
    repeat (4) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge mclk);
    chk({2'h0, ctrl}, ctrl_exp(CTRL_RESET_BASE, 1'b0));
    #1 power_good_input = 1'b1;
    repeat (4) @(posedge mclk);
    chk({2'h0, ctrl}, ctrl_exp(CTRL_RESET_BASE, 1'b1));
    chk({2'h0, alt_ctrl}, ctrl_exp(CTRL_RESET_ALT, 1'b1));
    host.wr(INDEX_PORT_ADDR, UNLOCK_KEY_ALT);
    host.wr(INDEX_PORT_ADDR, UNLOCK_KEY_ALT);
    chk({6'h0, alt_active, config_active}, 8'h02);
    host.wr(INDEX_PORT_ADDR, EXIT_KEY);
    chk({7'h0, alt_active}, 8'h00);
    host.rd(DATA_PORT_ADDR, rdata, roe);
    chk({7'h0, roe}, 8'h00);
    host.wr(INDEX_PORT_ADDR, 8'h00);
    host.wr(DATA_PORT_ADDR, 8'h00);
    host.wr(INDEX_PORT_ADDR, UNLOCK_KEY_BASE);
    host.wr(DATA_PORT_ADDR, 8'h11);
    host.wr(INDEX_PORT_ADDR, UNLOCK_KEY_BASE);
    chk({7'h0, config_active}, 8'h00);
    // half-entered key is dropped by the system reset, registers must survive it
    @(posedge mclk);
    #1 sys_reset = 1'b1;
    repeat (3) @(posedge mclk);
    #1 sys_reset = 1'b0;
    host.wr(INDEX_PORT_ADDR, UNLOCK_KEY_BASE);
    chk({7'h0, config_active}, 8'h00);
    host.wr(INDEX_PORT_ADDR, UNLOCK_KEY_BASE);
    chk({7'h0, config_active}, 8'h01);
    chk({7'h0, port_claim}, 8'h01);
    host.rd(DATA_PORT_ADDR, rdata, roe);
    chk({7'h0, roe}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      rdreg(4'(i), dflt[i]);
    end
    for (int i = 0; i < 4; i++) begin
      v = {i[0], i[1:0], i[1], i[0], 1'b0, ~i[0], i[1]};
      wrreg(IDX_CTRL, v);
      rdreg(IDX_CTRL, v & CTRL_WMASK);
      chk({2'h0, ctrl}, ctrl_exp(v, 1'b1));
      #1 power_good_input = 1'b0;
      repeat (4) @(posedge mclk);
      chk({2'h0, ctrl}, ctrl_exp(v, 1'b0));
      #1 power_good_input = 1'b1;
      repeat (4) @(posedge mclk);
    end
    wrreg(IDX_FIXED, 8'h00);
    rdreg(IDX_FIXED, 8'h01);
    wrreg(IDX_DRIVE_TYPES, 8'h5A);
    @(posedge mclk);
    #1 sys_reset = 1'b1;
    repeat (3) @(posedge mclk);
    #1 sys_reset = 1'b0;
    rdreg(IDX_DRIVE_TYPES, 8'h5A);
    host.wr(INDEX_PORT_ADDR, EXIT_KEY);
    chk({7'h0, config_active}, 8'h00);
    host.wr(DATA_PORT_ADDR, 8'h00);
    host.rd(DATA_PORT_ADDR, rdata, roe);
    chk({7'h0, roe}, 8'h00);
    chk({7'h0, port_claim}, 8'h00);
    enter();
    rdreg(IDX_DRIVE_TYPES, 8'h5A);
    @(posedge mclk);
    #1 arst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge mclk);
    chk({7'h0, config_active}, 8'h00);
    enter();
    rdreg(IDX_CTRL, CTRL_RESET_BASE);
    rdreg(IDX_DRIVE_TYPES, DRIVE_TYP_RESET);
    chk({2'h0, ctrl}, ctrl_exp(CTRL_RESET_BASE, 1'b1));
    finish_test();
  end
endmodule : config_register_bank_tb_top
`default_nettype wire
